// File: rtl/usb_interface_module.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
// How it works
// (R1) Non-held flags 6 to 2 return to zero at the start of each packet.
// (R2) Flag 6 sets on a token with good CRC5, good PID and our address.
// (R3) Flags 5, 4, 3 set on line state SE0, K and J.
// (R4) Flag 2 sets when a data packet fails CRC16.
// (R5) Flag 1 follows receive active, flag 0 follows receive error.
// (R6) Held flags keep their value until software writes one to them.
// (R7) Non-held flags may be overwritten by later signal changes.
// (R8) Each mask field ORs its selected flags onto one output port.
// (R9) An 11-bit frame counter is readable and writable in bits 10:0.
// (R10) The last received packet identifier is captured in bits 3:0.
// (R11) Last endpoint in bits 3:0, bit 4 set when it is valid.
// (R12) Marked endpoints are presented on the receive port ORed with 0x10.
// (R13) Control bit 18 disables the pull-downs on both wide ports.
// (R14) Auto-resume by SE0 sets bit 13; software writes zero to clear.
// (R15) Auto-resume by K sets bit 12; software writes zero to clear.
// (R16) A line-state change must be stable two to the n clocks first.
// (R17) Bit 7 hands resume to the suspend controller, else software polls.
// (R18) Control bits 6:4 drive the transceiver configuration pins.
// (R19) Tokens are accepted only for the programmed address, zero at reset.
// (R20) Port outputs are recomputed every clock from the flag contents.
// (R21) Reserved bits read as zero and ignore writes.
module usb_interface_module #(
    parameter int FILT_W = 16
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Transceiver side.
    input  wire logic [1:0]  line_state,
    input  wire logic        rx_active,
    input  wire logic        rx_error,
    output logic      [2:0]  transceiver_config_pins,
    output logic             wide_port_pulldown_off,
    // Packet decoder side.
    input  wire logic        pkt_start,
    input  wire logic        token_valid,
    input  wire logic        token_crc5_ok,
    input  wire logic        token_pid_ok,
    input  wire logic [6:0]  token_addr,
    input  wire logic [3:0]  token_endp,
    input  wire logic        pid_valid,
    input  wire logic [3:0]  pid_value,
    input  wire logic        data_crc16_bad,
    input  wire logic        sof_valid,
    input  wire logic [10:0] sof_frame,
    // Suspend controller side.
    input  wire logic        in_suspend,
    output logic             auto_resume,
    output logic      [1:0]  line_state_filt,
    // Flag ports and receive port.
    output logic             flag_out_port_a,
    output logic             flag_out_port_b,
    output logic             flag_out_port_c,
    output logic             flag_out_port_d,
    output logic      [4:0]  rx_endpoint
);

    logic [6:0]  dev_addr_r;
    logic [6:0]  flags_r;
    logic [6:0]  flag_hold_bits_r;
    logic [31:0] masks_r;
    logic [10:0] frame_count_r;
    logic [3:0]  last_pid_r;
    logic [4:0]  last_ep_r;
    logic [15:0] ep_mark_r;
    logic [31:0] otg_mask_value_r;
    logic [8:0]  pwr_sig_r;
    logic [31:0] phy_ctl_r;
    logic [1:0]  ls_cand_r;
    logic [FILT_W-1:0] ls_cnt_r;
    logic [6:0]  flag_evt;
    logic [6:0]  flag_nxt;
    logic        tok_ok;
    logic        wake_se0;
    logic        wake_k;

    function automatic logic hit(input logic [7:0] a);
        hit = reg_wr && (reg_addr == a);
    endfunction : hit

    // Address accepts only matching tokens; zero after reset.
    assign tok_ok = token_valid && token_crc5_ok && token_pid_ok
                    && (token_addr == dev_addr_r); // (R2) (R19)

    always_comb
    begin
        flag_evt = 7'h00;
        flag_evt[usb_flags_pkg::FLAG_TOKEN_OK]  = tok_ok; // (R2)
        flag_evt[usb_flags_pkg::FLAG_SE0]       = line_state_filt == usb_flags_pkg::LS_SE0; // (R3)
        flag_evt[usb_flags_pkg::FLAG_K]         = line_state_filt == usb_flags_pkg::LS_K; // (R3)
        flag_evt[usb_flags_pkg::FLAG_J]         = line_state_filt == usb_flags_pkg::LS_J; // (R3)
        flag_evt[usb_flags_pkg::FLAG_CRC16]     = data_crc16_bad; // (R4)
        flag_evt[usb_flags_pkg::FLAG_RX_ACTIVE] = rx_active; // (R5)
        flag_evt[usb_flags_pkg::FLAG_RX_ERROR]  = rx_error; // (R5)
    end

    // Held flags set on an event and clear on a written one, event winning.
    // Plain flags 1 and 0 are rewritten with the live level; the others set on an event and drop at packet start.
    always_comb
    begin
        flag_nxt = flags_r;
        for (int i = 0; i < usb_flags_pkg::NUM_FLAGS; i++)
        begin
            if (flag_hold_bits_r[i])
            begin
                if (hit(usb_flags_pkg::OFF_FLAGS) && reg_wdata[i])
                    flag_nxt[i] = 1'b0; // (R6)
                if (flag_evt[i])
                    flag_nxt[i] = 1'b1; // (R6)
            end
            else
            begin
                if (i == usb_flags_pkg::FLAG_RX_ACTIVE || i == usb_flags_pkg::FLAG_RX_ERROR)
                    flag_nxt[i] = flag_evt[i]; // (R5) (R7)
                else if (flag_evt[i])
                    flag_nxt[i] = 1'b1; // (R7)
                else if (pkt_start)
                    flag_nxt[i] = 1'b0; // (R1)
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            flags_r <= 7'h00;
        else
            flags_r <= flag_nxt;
    end

    // Plain control registers.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dev_addr_r       <= usb_flags_pkg::RESET_ADDR;
            flag_hold_bits_r <= 7'h00;
            masks_r          <= 32'h0000_0000;
            ep_mark_r        <= 16'h0000;
            otg_mask_value_r <= 32'h0000_0000;
            pwr_sig_r        <= 9'h000;
        end
        else
        begin
            if (hit(usb_flags_pkg::OFF_DEV_ADDR))
                dev_addr_r <= reg_wdata[6:0]; // (R19)
            if (hit(usb_flags_pkg::OFF_HOLD_SEL))
                flag_hold_bits_r <= reg_wdata[6:0]; // (R6) (R21)
            if (hit(usb_flags_pkg::OFF_MASKS))
                masks_r <= reg_wdata;
            if (hit(usb_flags_pkg::OFF_EP_MARK))
                ep_mark_r <= reg_wdata[15:0];
            if (hit(usb_flags_pkg::OFF_OTG_MASK))
                otg_mask_value_r <= reg_wdata;
            if (hit(usb_flags_pkg::OFF_PWR_SIG))
                pwr_sig_r <= reg_wdata[8:0]; // (R21)
        end
    end

    // Frame counter: software write, else loaded from each frame token.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            frame_count_r <= 11'h000;
        else if (hit(usb_flags_pkg::OFF_FRAME_COUNT))
            frame_count_r <= reg_wdata[10:0]; // (R9)
        else if (sof_valid)
            frame_count_r <= sof_frame; // (R9)
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            last_pid_r <= 4'h0;
            last_ep_r  <= 5'h00;
        end
        else
        begin
            if (pid_valid)
                last_pid_r <= pid_value; // (R10)
            if (tok_ok)
                last_ep_r <= {1'b1, token_endp}; // (R11)
        end
    end

    // Line-state filter: a new value must hold 2**n clocks.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ls_cand_r       <= 2'h1;
            ls_cnt_r        <= '0;
            line_state_filt <= 2'h1;
        end
        else if (line_state != ls_cand_r)
        begin
            ls_cand_r <= line_state;
            ls_cnt_r  <= '0;
        end
        else if (line_state != line_state_filt)
        begin
            if ({1'b0, ls_cnt_r} + 1'b1 >= (FILT_W + 1)'(1) << phy_ctl_r[11:8])
            begin
                line_state_filt <= ls_cand_r; // (R16)
                ls_cnt_r        <= '0;
            end
            else
                ls_cnt_r <= ls_cnt_r + 1'b1; // (R16)
        end
    end

    // Automatic resume only while the suspend controller owns wake-up.
    assign wake_se0 = in_suspend && phy_ctl_r[usb_flags_pkg::PHY_AUTO_RESUME]
                      && line_state_filt == usb_flags_pkg::LS_SE0; // (R17)
    assign wake_k = in_suspend && phy_ctl_r[usb_flags_pkg::PHY_AUTO_RESUME]
                    && line_state_filt == usb_flags_pkg::LS_K; // (R17)

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            phy_ctl_r <= 32'h0000_0000;
        else
        begin
            if (hit(usb_flags_pkg::OFF_PHY_CTL))
                phy_ctl_r <= reg_wdata & usb_flags_pkg::PHY_CTL_WMASK; // (R21)
            if (wake_se0)
                phy_ctl_r[usb_flags_pkg::PHY_WAKE_SE0] <= 1'b1; // (R14)
            if (wake_k)
                phy_ctl_r[usb_flags_pkg::PHY_WAKE_K] <= 1'b1; // (R15)
        end
    end

    // Registered outputs.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            flag_out_port_a         <= 1'b0;
            flag_out_port_b         <= 1'b0;
            flag_out_port_c         <= 1'b0;
            flag_out_port_d         <= 1'b0;
            rx_endpoint             <= 5'h00;
            transceiver_config_pins <= 3'h0;
            wide_port_pulldown_off  <= 1'b0;
            auto_resume             <= 1'b0;
        end
        else
        begin
            flag_out_port_a <= |(flags_r & masks_r[6:0]); // (R8) (R20)
            flag_out_port_b <= |(flags_r & masks_r[14:8]); // (R8) (R20)
            flag_out_port_c <= |(flags_r & masks_r[22:16]); // (R8) (R20)
            flag_out_port_d <= |(flags_r & masks_r[30:24]); // (R8) (R20)
            rx_endpoint <= ep_mark_r[last_ep_r[3:0]]
                           ? ({1'b0, last_ep_r[3:0]} | usb_flags_pkg::EP_MARK_OR)
                           : {1'b0, last_ep_r[3:0]}; // (R12)
            transceiver_config_pins <= phy_ctl_r[6:4]; // (R18)
            wide_port_pulldown_off  <= phy_ctl_r[usb_flags_pkg::PHY_NO_PULLDOWN]; // (R13)
            auto_resume             <= wake_se0 || wake_k; // (R17)
        end
    end

    // Read port, data one cycle after the strobe.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                usb_flags_pkg::OFF_DEV_ADDR:    reg_rdata <= {25'h0, dev_addr_r};
                usb_flags_pkg::OFF_FLAGS:       reg_rdata <= {25'h0, flags_r};
                usb_flags_pkg::OFF_HOLD_SEL:    reg_rdata <= {25'h0, flag_hold_bits_r};
                usb_flags_pkg::OFF_MASKS:       reg_rdata <= masks_r;
                usb_flags_pkg::OFF_FRAME_COUNT: reg_rdata <= {21'h0, frame_count_r};
                usb_flags_pkg::OFF_LAST_PID:    reg_rdata <= {28'h0, last_pid_r};
                usb_flags_pkg::OFF_LAST_EP:     reg_rdata <= {27'h0, last_ep_r};
                usb_flags_pkg::OFF_EP_MARK:     reg_rdata <= {16'h0, ep_mark_r};
                usb_flags_pkg::OFF_OTG_MASK:    reg_rdata <= otg_mask_value_r;
                usb_flags_pkg::OFF_PWR_SIG:     reg_rdata <= {23'h0, pwr_sig_r};
                usb_flags_pkg::OFF_PHY_CTL:     reg_rdata <= phy_ctl_r; // (R21)
                default:                        reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata <= 32'h0000_0000;
    end

    // Each output port follows its masked flags one clock later.
    flag_port_a_a: assert property (@(posedge clk) disable iff (!rstn) // (R8) (R20)
        1'b1 |=> flag_out_port_a == |($past(flags_r) & $past(masks_r[6:0])))
        else $error("port a does not follow masked flags");
    port_b_a: assert property (@(posedge clk) disable iff (!rstn) // (R8) (R20)
        1'b1 |=> flag_out_port_b == |($past(flags_r) & $past(masks_r[14:8])))
        else $error("port b does not follow masked flags");
    port_c_a: assert property (@(posedge clk) disable iff (!rstn) // (R8) (R20)
        1'b1 |=> flag_out_port_c == |($past(flags_r) & $past(masks_r[22:16])))
        else $error("port c does not follow masked flags");
    port_d_a: assert property (@(posedge clk) disable iff (!rstn) // (R8) (R20)
        1'b1 |=> flag_out_port_d == |($past(flags_r) & $past(masks_r[30:24])))
        else $error("port d does not follow masked flags");
    rx_follow_a: assert property (@(posedge clk) disable iff (!rstn) // (R5)
        ##1 !$past(flag_hold_bits_r[1]) |-> flags_r[1] == $past(rx_active))
        else $error("flag 1 does not follow receive active");
    rx_error_a: assert property (@(posedge clk) disable iff (!rstn) // (R5)
        ##1 !$past(flag_hold_bits_r[0]) |-> flags_r[0] == $past(rx_error))
        else $error("flag 0 does not follow receive error");
    held_flag_a: assert property (@(posedge clk) disable iff (!rstn) // (R6)
        flag_hold_bits_r[3] && flags_r[3] && !(reg_wr && reg_addr == usb_flags_pkg::OFF_FLAGS)
        |=> flags_r[3])
        else $error("held flag dropped without a write");
    held_clear_a: assert property (@(posedge clk) disable iff (!rstn) // (R6)
        flag_hold_bits_r[4] && reg_wr && reg_addr == usb_flags_pkg::OFF_FLAGS && reg_wdata[4]
        && line_state_filt != usb_flags_pkg::LS_K |=> !flags_r[4])
        else $error("held flag not cleared by a written one");
    set_wins_a: assert property (@(posedge clk) disable iff (!rstn) // (R6)
        flag_hold_bits_r[4] && line_state_filt == usb_flags_pkg::LS_K |=> flags_r[4])
        else $error("held flag event lost");
    pkt_clear_a: assert property (@(posedge clk) disable iff (!rstn) // (R1)
        pkt_start && !flag_hold_bits_r[2] && !data_crc16_bad |=> !flags_r[2])
        else $error("plain flag survived packet start");
    token_flag_a: assert property (@(posedge clk) disable iff (!rstn) // (R2)
        token_valid && token_crc5_ok && token_pid_ok && token_addr == dev_addr_r
        |=> flags_r[6] && last_ep_r[4])
        else $error("good token not flagged");
    ep_stable_a: assert property (@(posedge clk) disable iff (!rstn) // (R11) (R19)
        !tok_ok |=> $stable(last_ep_r))
        else $error("endpoint changed without an accepted token");
    // Registered copies of the control and capture registers.
    conf_pins_a: assert property (@(posedge clk) disable iff (!rstn) // (R18)
        ##1 transceiver_config_pins == $past(phy_ctl_r[6:4]))
        else $error("config pins do not follow control");
    pulldown_a: assert property (@(posedge clk) disable iff (!rstn) // (R13)
        ##1 wide_port_pulldown_off == $past(phy_ctl_r[usb_flags_pkg::PHY_NO_PULLDOWN]))
        else $error("pulldown control does not follow control");
    reserved_a: assert property (@(posedge clk) disable iff (!rstn) // (R21)
        (phy_ctl_r & ~usb_flags_pkg::PHY_CTL_WMASK) == 32'h0000_0000)
        else $error("reserved control bit set");
    wake_k_a: assert property (@(posedge clk) disable iff (!rstn) // (R15)
        wake_k |=> phy_ctl_r[12])
        else $error("wake by k not recorded");
    wake_se0_a: assert property (@(posedge clk) disable iff (!rstn) // (R14)
        wake_se0 |=> phy_ctl_r[13])
        else $error("wake by se0 not recorded");
    auto_off_a: assert property (@(posedge clk) disable iff (!rstn) // (R17)
        !phy_ctl_r[usb_flags_pkg::PHY_AUTO_RESUME] |=> !auto_resume)
        else $error("auto resume while software owns wake-up");
    filt_take_a: assert property (@(posedge clk) disable iff (!rstn) // (R16)
        $changed(line_state_filt) |-> line_state_filt == $past(line_state))
        else $error("filtered line state took an unstable value");
    pid_capture_a: assert property (@(posedge clk) disable iff (!rstn) // (R10)
        pid_valid |=> last_pid_r == $past(pid_value))
        else $error("pid not captured");
    pid_stable_a: assert property (@(posedge clk) disable iff (!rstn) // (R10)
        !pid_valid |=> $stable(last_pid_r))
        else $error("pid changed without a packet");
    frame_write_a: assert property (@(posedge clk) disable iff (!rstn) // (R9)
        reg_wr && reg_addr == usb_flags_pkg::OFF_FRAME_COUNT |=> frame_count_r == $past(reg_wdata[10:0]))
        else $error("frame counter write lost");
    frame_sof_a: assert property (@(posedge clk) disable iff (!rstn) // (R9)
        sof_valid && !(reg_wr && reg_addr == usb_flags_pkg::OFF_FRAME_COUNT)
        |=> frame_count_r == $past(sof_frame))
        else $error("frame counter not loaded from frame token");
    ep_mark_a: assert property (@(posedge clk) disable iff (!rstn) // (R12)
        1'b1 |=> rx_endpoint == ({1'b0, $past(last_ep_r[3:0])}
        | ($past(ep_mark_r[last_ep_r[3:0]]) ? usb_flags_pkg::EP_MARK_OR : 5'h00)))
        else $error("receive port endpoint wrong");

endmodule : usb_interface_module
`default_nettype wire

// File: include/usb_flags_pkg.sv
`default_nettype none
package usb_flags_pkg;
    localparam logic [7:0] OFF_DEV_ADDR    = 8'h08;
    localparam logic [7:0] OFF_FLAGS       = 8'h1c;
    localparam logic [7:0] OFF_HOLD_SEL    = 8'h20;
    localparam logic [7:0] OFF_MASKS       = 8'h24;
    localparam logic [7:0] OFF_FRAME_COUNT = 8'h28;
    localparam logic [7:0] OFF_LAST_PID    = 8'h2c;
    localparam logic [7:0] OFF_LAST_EP     = 8'h30;
    localparam logic [7:0] OFF_EP_MARK     = 8'h34;
    localparam logic [7:0] OFF_OTG_MASK    = 8'h38;
    localparam logic [7:0] OFF_PWR_SIG     = 8'h3c;
    localparam logic [7:0] OFF_PHY_CTL     = 8'h40;
    localparam int NUM_FLAGS        = 7;
    localparam int FLAG_TOKEN_OK    = 6;
    localparam int FLAG_SE0         = 5;
    localparam int FLAG_K           = 4;
    localparam int FLAG_J           = 3;
    localparam int FLAG_CRC16       = 2;
    localparam int FLAG_RX_ACTIVE   = 1;
    localparam int FLAG_RX_ERROR    = 0;
    localparam int EP_VALID_BIT     = 4;
    localparam int PHY_NO_PULLDOWN  = 18;
    localparam int PHY_WAKE_SE0     = 13;
    localparam int PHY_WAKE_K       = 12;
    localparam int PHY_FILT_LSB     = 8;
    localparam int PHY_AUTO_RESUME  = 7;
    localparam int PHY_CONF_LSB     = 4;
    localparam logic [31:0] PHY_CTL_WMASK = 32'h0004_3ff0;
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_J   = 2'h1;
    localparam logic [1:0] LS_K   = 2'h2;
    localparam logic [4:0] EP_MARK_OR = 5'h10;
    localparam logic [6:0] RESET_ADDR = 7'h00;
endpackage : usb_flags_pkg
`default_nettype wire

// File: tb/far_side.sv
`timescale 1ns/100ps
`default_nettype none
module far_side (
    // Clock.
    input  wire logic        clk,
    // Transceiver levels.
    output logic      [1:0]  line_state,
    output logic             rx_active,
    output logic             rx_error,
    // Decoded packet events.
    output logic             pkt_start,
    output logic             token_valid,
    output logic             token_crc5_ok,
    output logic             token_pid_ok,
    output logic      [6:0]  token_addr,
    output logic      [3:0]  token_endp,
    output logic             pid_valid,
    output logic      [3:0]  pid_value,
    output logic             data_crc16_bad,
    output logic             sof_valid,
    output logic      [10:0] sof_frame
);
    initial
    begin
        {rx_active, rx_error, pkt_start, token_valid, token_crc5_ok} = 5'h00;
        {token_pid_ok, pid_valid, data_crc16_bad, sof_valid} = 4'h0;
        {token_addr, token_endp, pid_value, sof_frame} = 26'h0;
        line_state = 2'h1;
    end
    task automatic levels(input logic [1:0] ls, input logic act, input logic err);
        @(posedge clk);
        line_state <= ls;
        rx_active  <= act;
        rx_error   <= err;
    endtask : levels
    task automatic start;
        @(posedge clk);
        pkt_start <= 1'b1;
        @(posedge clk);
        pkt_start <= 1'b0;
    endtask : start
    // Fields are scrambled outside the pulse so a stale value can never be mistaken for news.
    task automatic token(input logic [6:0] a, input logic [3:0] e, input logic good);
        start();
        {token_valid, token_crc5_ok, token_pid_ok, token_addr, token_endp} <= {2'h1, good, 1'b1, a, e};
        @(posedge clk);
        {token_valid, token_crc5_ok, token_pid_ok, token_addr, token_endp} <= {3'h0, ~a, ~e};
    endtask : token
    task automatic packet(input logic [3:0] p, input logic bad);
        start();
        {pid_valid, pid_value, data_crc16_bad} <= {1'b1, p, bad};
        @(posedge clk);
        {pid_valid, pid_value, data_crc16_bad} <= {1'b0, ~p, 1'b0};
    endtask : packet
    task automatic sof(input logic [10:0] f);
        @(posedge clk);
        {sof_valid, sof_frame} <= {1'b1, f};
        @(posedge clk);
        {sof_valid, sof_frame} <= {1'b0, ~f};
    endtask : sof
endmodule : far_side
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clk, rstn, reg_wr, reg_rd, in_suspend, rx_active, rx_error, pkt_start;
    logic        token_valid, token_crc5_ok, token_pid_ok, pid_valid, data_crc16_bad, sof_valid;
    logic        wide_port_pulldown_off, auto_resume;
    logic        flag_out_port_a, flag_out_port_b, flag_out_port_c, flag_out_port_d;
    logic [1:0]  line_state, line_state_filt;
    logic [2:0]  transceiver_config_pins;
    logic [3:0]  token_endp, pid_value, ports;
    logic [4:0]  rx_endpoint;
    logic [6:0]  token_addr;
    logic [7:0]  reg_addr;
    logic [10:0] sof_frame;
    logic [31:0] reg_wdata, reg_rdata;
    int          bad_count, samples_checked;
    localparam logic [7:0]  OFFS [10] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38,
                                          8'h3c, 8'h40, 8'h44};
    localparam logic [31:0] EXPS [10] = '{32'h7f, 32'hffffffff, 32'h7ff, 32'h0, 32'h0,
                                          32'hffff, 32'hffffffff, 32'h1ff, 32'h43ff0, 32'h0};
    assign ports = {flag_out_port_a, flag_out_port_b, flag_out_port_c, flag_out_port_d};
    usb_interface_module dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .line_state, .rx_active, .rx_error, .transceiver_config_pins, .wide_port_pulldown_off,
        .pkt_start, .token_valid, .token_crc5_ok, .token_pid_ok, .token_addr, .token_endp,
        .pid_valid, .pid_value, .data_crc16_bad, .sof_valid, .sof_frame, .in_suspend,
        .auto_resume, .line_state_filt, .flag_out_port_a, .flag_out_port_b, .flag_out_port_c,
        .flag_out_port_d, .rx_endpoint);
    far_side far (.clk, .line_state, .rx_active, .rx_error, .pkt_start, .token_valid,
        .token_crc5_ok, .token_pid_ok, .token_addr, .token_endp, .pid_valid, .pid_value,
        .data_crc16_bad, .sof_valid, .sof_frame);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata & m, exp);
    endtask : rc
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    task automatic report_and_stop;
        if (bad_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    initial
    begin
        #100000;
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        {bad_count, samples_checked, rstn, reg_wr, reg_rd, in_suspend} = '0;
        {reg_addr, reg_wdata} = '0;
        idle(10);
        chk({line_state_filt, transceiver_config_pins, wide_port_pulldown_off, auto_resume,
             ports, rx_endpoint}, 32'h4000);
        rstn <= 1'b1;
        foreach (OFFS[i]) rc(OFFS[i], 32'hffffffff, 32'h0);
        rc(8'h1c, 32'h47, 32'h0);
        foreach (OFFS[i]) wr(OFFS[i], 32'hffffffff);
        foreach (OFFS[i]) rc(OFFS[i], 32'hffffffff, EXPS[i]);
        chk({transceiver_config_pins, wide_port_pulldown_off}, 32'hf);
        foreach (OFFS[i]) wr(OFFS[i], 32'h0);
        chk({transceiver_config_pins, wide_port_pulldown_off}, 32'h0);
        wr(8'h1c, 32'h7f);
        wr(8'h08, 32'h5);
        rc(8'h08, 32'hffffffff, 32'h5);
        // Non-held K flag is wiped by the next packet, which is also a good token.
        far.levels(2'h2, 1'b0, 1'b0);
        idle(6);
        rc(8'h1c, 32'h10, 32'h10);
        far.levels(2'h1, 1'b0, 1'b0);
        idle(2);
        far.token(7'h05, 4'h9, 1'b1);
        idle(2);
        rc(8'h1c, 32'h50, 32'h40);
        rc(8'h30, 32'hffffffff, 32'h19);
        chk(rx_endpoint, 32'h09);
        wr(8'h34, 32'h200);
        idle(2);
        chk(rx_endpoint, 32'h19);
        // Held K flag survives packets; foreign address and bad CRC5 tokens are ignored.
        wr(8'h20, 32'h10);
        far.levels(2'h2, 1'b0, 1'b0);
        idle(6);
        far.levels(2'h1, 1'b0, 1'b0);
        far.token(7'h03, 4'h2, 1'b1);
        far.token(7'h05, 4'h2, 1'b0);
        idle(2);
        rc(8'h1c, 32'h50, 32'h10);
        wr(8'h1c, 32'h10);
        rc(8'h1c, 32'h10, 32'h0);
        wr(8'h24, 32'h04200102);
        far.levels(2'h1, 1'b1, 1'b1);
        idle(3);
        rc(8'h1c, 32'h3, 32'h3);
        chk(ports, 32'hc);
        far.levels(2'h1, 1'b0, 1'b0);
        idle(3);
        chk(ports, 32'h0);
        rc(8'h1c, 32'h3, 32'h0);
        far.packet(4'hd, 1'b1);
        idle(2);
        rc(8'h2c, 32'hffffffff, 32'hd);
        rc(8'h1c, 32'h4, 32'h4);
        chk(ports, 32'h1);
        far.sof(11'h5a3);
        idle(2);
        rc(8'h28, 32'hffffffff, 32'h5a3);
        // Filter of two to the third clocks.
        wr(8'h40, 32'h300);
        far.levels(2'h2, 1'b0, 1'b0);
        idle(5);
        chk(line_state_filt, 32'h1);
        idle(8);
        chk(line_state_filt, 32'h2);
        far.levels(2'h1, 1'b0, 1'b0);
        wr(8'h40, 32'h0);
        idle(4);
        in_suspend <= 1'b1;
        far.levels(2'h0, 1'b0, 1'b0);
        idle(4);
        chk(auto_resume, 32'h0);
        rc(8'h40, 32'h3000, 32'h0);
        wr(8'h40, 32'h80);
        idle(3);
        chk(auto_resume, 32'h1);
        chk(flag_out_port_c, 32'h1);
        rc(8'h1c, 32'h20, 32'h20);
        in_suspend <= 1'b0;
        far.levels(2'h1, 1'b0, 1'b0);
        idle(4);
        rc(8'h40, 32'h3000, 32'h2000);
        wr(8'h40, 32'h80);
        rc(8'h40, 32'h3000, 32'h0);
        in_suspend <= 1'b1;
        far.levels(2'h2, 1'b0, 1'b0);
        idle(4);
        in_suspend <= 1'b0;
        far.levels(2'h1, 1'b0, 1'b0);
        idle(4);
        rc(8'h40, 32'h3000, 32'h1000);
        wr(8'h40, 32'h80);
        rc(8'h40, 32'h3000, 32'h0);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
